// File: common/rsp_pkg.sv
package rsp_pkg;

  // ****************************************
  // clock and silence timing
  // ****************************************
  localparam int CLK_FREQ_HZ = 50000000;
  localparam int GAP_W = 24;
  localparam int GAP_HALF_CHARS = 7;
  localparam int CHAR_BITS_PLAIN = 10;
  localparam int CHAR_BITS_EXT = 11;
  localparam int BAUD_TAB [6] = '{2400, 4800, 9600, 19200, 38400, 57600};
  localparam logic [2:0] BAUD_MAX_SEL = 3'h5;
  localparam logic [2:0] BAUD_DEF_SEL = 3'h2;
  localparam logic [1:0] FMT_1S_NONE = 2'h0;
  localparam logic [1:0] FMT_1S_ODD = 2'h1;
  localparam logic [1:0] FMT_1S_EVEN = 2'h2;
  localparam logic [1:0] FMT_2S_NONE = 2'h3;

  // ****************************************
  // command and exception codes
  // ****************************************
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_WRITE16 = 8'h06;
  localparam logic [7:0] CMD_WRITE32 = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_CMD = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_DATA = 8'h03;
  localparam logic [7:0] EXC_FAIL = 8'h04;

  // ****************************************
  // check code
  // ****************************************
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;

  // ****************************************
  // address space
  // ****************************************
  localparam logic [15:0] PAR_LO = 16'h0001;
  localparam logic [15:0] PAR_HI = 16'h0d08;
  localparam logic [15:0] MON_LO = 16'h1e01;
  localparam logic [15:0] MON_HI = 16'h2010;

  // ****************************************
  // frame layout
  // ****************************************
  localparam int RX_DEPTH = 16;
  localparam int MAX_RD = 8;
  localparam logic [4:0] RX_FULL = 5'h10;
  localparam logic [4:0] MIN_LEN = 5'h04;
  localparam logic [4:0] REQ_LEN = 5'h08;
  localparam logic [4:0] WR32_LEN = 5'h0d;
  localparam logic [15:0] WR32_REGS = 16'h0002;
  localparam logic [7:0] WR32_BYTES = 8'h04;
  localparam logic [15:0] RD_MAX_REGS = 16'h0008;
  localparam int POS_STA = 0;
  localparam int POS_CMD = 1;
  localparam int POS_AH = 2;
  localparam int POS_AL = 3;
  localparam int POS_NH = 4;
  localparam int POS_NL = 5;
  localparam int POS_BC = 6;
  localparam int POS_D0 = 7;
  localparam logic [4:0] EXC_BODY_LEN = 5'h03;
  localparam logic [4:0] WR_BODY_LEN = 5'h06;
  localparam logic [4:0] RD_HDR_LEN = 5'h03;
  localparam logic [4:0] IDX_CMD = 5'h01;
  localparam logic [4:0] IDX_CODE = 5'h02;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    S_RX = 4'b0001,
    S_ACC = 4'b0010,
    S_SEND = 4'b0100,
    S_DRAIN = 4'b1000
  } rsp_state_t;

  typedef logic [GAP_W-1:0] rsp_gap_tab_t [6];

  // silence limit per bit rate, rounded up to whole cycles
  function automatic rsp_gap_tab_t rsp_gap_tab(input int clk_hz,
                                               input int bits);
    rsp_gap_tab_t t;
    logic [39:0] num;
    logic [39:0] den;
    for (int k = 0; k < 6; k++) begin
      num = 40'(clk_hz) * 40'(bits) * 40'(GAP_HALF_CHARS);
      den = 40'h2 * 40'(BAUD_TAB[k]);
      t[k] = GAP_W'((num + den - 40'h1) / den);
    end
    return t;
  endfunction

endpackage

// File: core/rsp_crc16.sv
`timescale 1ns/1ps
module rsp_crc16 import rsp_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] data,
  // result
  output logic [15:0] crc
);

  logic [15:0] crc_r;
  logic [15:0] crc_nxt;
  logic [15:0] c;

  // ****************************************
  // byte step
  // ****************************************
  always_comb begin
    c = crc_r ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      if (c[0]) begin
        c = (c >> 1) ^ CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    crc_nxt = crc_r;
    if (clr) begin
      crc_nxt = CRC_INIT;
    end else if (en) begin
      crc_nxt = c;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      crc_r <= CRC_INIT;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign crc = crc_r;

endmodule

// File: core/rsp_engine.sv
`timescale 1ns/1ps
module rsp_engine import rsp_pkg::*; #(
  parameter int CLK_HZ = CLK_FREQ_HZ
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // link settings
  input wire logic [7:0] station_address_setting,
  input wire logic [2:0] bit_rate_setting,
  input wire logic [1:0] character_format_setting,
  input wire logic word_order_setting,
  // received bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  // transmitted bytes
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  input wire logic tx_idle,
  output logic tx_drive_en,
  // parameter store access
  output logic reg_req,
  output logic reg_we,
  output logic reg_wide,
  output logic [15:0] reg_addr,
  output logic [31:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic reg_err,
  input wire logic [15:0] reg_rdata,
  // status
  output logic frame_drop
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic in_par(input logic [15:0] a);
    return (a >= PAR_LO) && (a <= PAR_HI);
  endfunction

  function automatic logic in_mon(input logic [15:0] a);
    return (a >= MON_LO) && (a <= MON_HI);
  endfunction

  localparam rsp_gap_tab_t GAP_PLAIN = rsp_gap_tab(CLK_HZ, CHAR_BITS_PLAIN);
  localparam rsp_gap_tab_t GAP_EXT = rsp_gap_tab(CLK_HZ, CHAR_BITS_EXT);

  // ****************************************
  // declarations
  // ****************************************
  rsp_state_t state_r, state_nxt;
  logic [GAP_W-1:0] gap_r, gap_nxt, gap_lim;
  logic quiet_r, quiet_nxt;
  logic bad_r, bad_nxt;
  logic [4:0] len_r, len_nxt;
  logic [7:0] buf_r [RX_DEPTH];
  logic [7:0] buf_nxt [RX_DEPTH];
  logic [15:0] rd_buf_r [MAX_RD];
  logic [15:0] rd_buf_nxt [MAX_RD];
  logic [4:0] idx_r, idx_nxt;
  logic [7:0] exc_r, exc_nxt, exc_dec;
  logic pend_r, pend_nxt;
  logic tx_valid_r, tx_valid_nxt;
  logic [7:0] tx_byte_r, tx_byte_nxt;
  logic tx_dir_r, tx_dir_nxt;
  logic reg_req_r, reg_req_nxt;
  logic reg_we_r, reg_we_nxt;
  logic reg_wide_r, reg_wide_nxt;
  logic [15:0] reg_addr_r, reg_addr_nxt;
  logic [31:0] reg_wdata_r, reg_wdata_nxt;
  logic drop_r, drop_nxt;
  logic [2:0] rate_sel;
  logic reached, frame_end, rx_open;
  logic rx_crc_clr, rx_crc_en, tx_crc_clr, tx_crc_en;
  logic [15:0] rx_crc, tx_crc;
  logic [7:0] cmd;
  logic [15:0] a_start, n_regs, a_last, w0, w1;
  logic [4:0] blen, rd_off;
  logic [7:0] body;

  // ****************************************
  // check code units
  // ****************************************
  rsp_crc16 u_rx_crc (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clr(rx_crc_clr),
    .en(rx_crc_en),
    .data(rx_byte),
    .crc(rx_crc)
  );

  rsp_crc16 u_tx_crc (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clr(tx_crc_clr),
    .en(tx_crc_en),
    .data(tx_byte_r),
    .crc(tx_crc)
  );

  // ****************************************
  // frame receive and silence timing
  // ****************************************
  always_comb begin
    rate_sel = (bit_rate_setting > BAUD_MAX_SEL) ? BAUD_DEF_SEL
                                                 : bit_rate_setting;
    gap_lim = (character_format_setting == FMT_1S_NONE) ?
              GAP_PLAIN[rate_sel] : GAP_EXT[rate_sel];
    reached = (gap_r >= gap_lim);
    rx_open = (state_r == S_RX);
    frame_end = reached && !quiet_r && (len_r != 5'h00) && !rx_valid;
    gap_nxt = gap_r;
    quiet_nxt = quiet_r;
    len_nxt = len_r;
    bad_nxt = bad_r;
    buf_nxt = buf_r;
    rx_crc_clr = 1'b0;
    rx_crc_en = 1'b0;
    if (rx_valid) begin
      gap_nxt = '0;
      quiet_nxt = 1'b0;
      if (rx_open) begin
        rx_crc_en = 1'b1;
        if ((len_r == 5'h00) && !quiet_r) begin
          bad_nxt = 1'b1;
        end
        if (len_r == RX_FULL) begin
          bad_nxt = 1'b1;
        end else begin
          buf_nxt[len_r[3:0]] = rx_byte;
          len_nxt = len_r + 5'h01;
        end
      end
    end else begin
      if (!reached) begin
        gap_nxt = gap_r + GAP_W'(1);
      end
      quiet_nxt = reached;
      if (frame_end) begin
        len_nxt = 5'h00;
        bad_nxt = 1'b0;
        rx_crc_clr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gap_r <= '0;
      quiet_r <= 1'b0;
      len_r <= 5'h00;
      bad_r <= 1'b0;
      for (int i = 0; i < RX_DEPTH; i++) begin
        buf_r[i] <= 8'h00;
      end
    end else begin
      gap_r <= gap_nxt;
      quiet_r <= quiet_nxt;
      len_r <= len_nxt;
      bad_r <= bad_nxt;
      buf_r <= buf_nxt;
    end
  end

  // ****************************************
  // request decode
  // ****************************************
  always_comb begin
    cmd = buf_r[POS_CMD];
    a_start = {buf_r[POS_AH], buf_r[POS_AL]};
    n_regs = {buf_r[POS_NH], buf_r[POS_NL]};
    a_last = a_start + n_regs - 16'h0001;
    w0 = {buf_r[POS_D0], buf_r[POS_D0 + 1]};
    w1 = {buf_r[POS_D0 + 2], buf_r[POS_D0 + 3]};
    exc_dec = EXC_NONE;
    case (cmd)
      CMD_READ: begin
        if ((len_r != REQ_LEN) || (n_regs == 16'h0000) ||
            (n_regs > RD_MAX_REGS)) begin
          exc_dec = EXC_DATA;
        end else if (!((in_par(a_start) && in_par(a_last)) ||
                       (in_mon(a_start) && in_mon(a_last)))) begin
          exc_dec = EXC_ADDR;
        end
      end
      CMD_WRITE16: begin
        if (len_r != REQ_LEN) begin
          exc_dec = EXC_DATA;
        end else if (!in_par(a_start)) begin
          exc_dec = EXC_ADDR;
        end
      end
      CMD_WRITE32: begin
        if ((len_r != WR32_LEN) || (n_regs != WR32_REGS) ||
            (buf_r[POS_BC] != WR32_BYTES)) begin
          exc_dec = EXC_DATA;
        end else if (!(in_par(a_start) &&
                       in_par(a_start + 16'h0001))) begin
          exc_dec = EXC_ADDR;
        end
      end
      default: begin
        exc_dec = EXC_CMD;
      end
    endcase
  end

  // ****************************************
  // reply bytes
  // ****************************************
  always_comb begin
    rd_off = idx_r - RD_HDR_LEN;
    if (exc_r != EXC_NONE) begin
      blen = EXC_BODY_LEN;
      if (idx_r == IDX_CMD) begin
        body = cmd | EXC_FLAG;
      end else if (idx_r == IDX_CODE) begin
        body = exc_r;
      end else begin
        body = buf_r[POS_STA];
      end
    end else if (cmd == CMD_READ) begin
      blen = RD_HDR_LEN + {n_regs[3:0], 1'b0};
      if (idx_r < IDX_CODE) begin
        body = buf_r[idx_r[3:0]];
      end else if (idx_r == IDX_CODE) begin
        body = {3'h0, n_regs[3:0], 1'b0};
      end else if (!rd_off[0]) begin
        body = rd_buf_r[rd_off[3:1]][15:8];
      end else begin
        body = rd_buf_r[rd_off[3:1]][7:0];
      end
    end else begin
      blen = WR_BODY_LEN;
      body = buf_r[idx_r[3:0]];
    end
  end

  // ****************************************
  // control sequence
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    exc_nxt = exc_r;
    pend_nxt = pend_r;
    rd_buf_nxt = rd_buf_r;
    tx_valid_nxt = tx_valid_r;
    tx_byte_nxt = tx_byte_r;
    tx_dir_nxt = tx_dir_r;
    reg_req_nxt = 1'b0;
    reg_we_nxt = reg_we_r;
    reg_wide_nxt = reg_wide_r;
    reg_addr_nxt = reg_addr_r;
    reg_wdata_nxt = reg_wdata_r;
    drop_nxt = 1'b0;
    tx_crc_clr = 1'b0;
    tx_crc_en = 1'b0;
    unique case (state_r)
      S_RX: begin
        if (frame_end) begin
          if ((len_r < MIN_LEN) || (rx_crc != CRC_GOOD) || bad_r) begin
            drop_nxt = 1'b1;
          end else if (buf_r[POS_STA] == station_address_setting) begin
            idx_nxt = 5'h00;
            pend_nxt = 1'b0;
            exc_nxt = exc_dec;
            tx_crc_clr = 1'b1;
            if (exc_dec != EXC_NONE) begin
              state_nxt = S_SEND;
              tx_dir_nxt = 1'b1;
            end else begin
              state_nxt = S_ACC;
            end
          end
        end
      end
      S_ACC: begin
        if (!pend_r) begin
          reg_req_nxt = 1'b1;
          pend_nxt = 1'b1;
          reg_addr_nxt = a_start + {11'h000, idx_r};
          reg_we_nxt = (cmd != CMD_READ);
          reg_wide_nxt = (cmd == CMD_WRITE32);
          if (cmd == CMD_WRITE32) begin
            reg_wdata_nxt = word_order_setting ? {w1, w0}
                                               : {w0, w1};
          end else begin
            reg_wdata_nxt = {16'h0000, n_regs};
          end
        end else if (reg_ack && !reg_req_r) begin
          pend_nxt = 1'b0;
          if (reg_err) begin
            exc_nxt = EXC_FAIL;
            idx_nxt = 5'h00;
            state_nxt = S_SEND;
            tx_dir_nxt = 1'b1;
          end else if ((cmd == CMD_READ) &&
                       ((idx_r + 5'h01) != n_regs[4:0])) begin
            rd_buf_nxt[idx_r[2:0]] = reg_rdata;
            idx_nxt = idx_r + 5'h01;
          end else begin
            rd_buf_nxt[idx_r[2:0]] = reg_rdata;
            idx_nxt = 5'h00;
            state_nxt = S_SEND;
            tx_dir_nxt = 1'b1;
          end
        end
      end
      S_SEND: begin
        if (!tx_valid_r) begin
          tx_valid_nxt = 1'b1;
          if (idx_r < blen) begin
            tx_byte_nxt = body;
          end else if (idx_r == blen) begin
            tx_byte_nxt = tx_crc[7:0];
          end else begin
            tx_byte_nxt = tx_crc[15:8];
          end
        end else if (tx_ready) begin
          tx_valid_nxt = 1'b0;
          tx_crc_en = (idx_r < blen);
          if (idx_r == blen + 5'h01) begin
            state_nxt = S_DRAIN;
          end else begin
            idx_nxt = idx_r + 5'h01;
          end
        end
      end
      S_DRAIN: begin
        if (tx_idle) begin
          tx_dir_nxt = 1'b0;
          state_nxt = S_RX;
        end
      end
      default: begin
        state_nxt = S_RX;
        tx_dir_nxt = 1'b0;
        tx_valid_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= S_RX;
      idx_r <= 5'h00;
      exc_r <= EXC_NONE;
      pend_r <= 1'b0;
      for (int i = 0; i < MAX_RD; i++) begin
        rd_buf_r[i] <= 16'h0000;
      end
      tx_valid_r <= 1'b0;
      tx_byte_r <= 8'h00;
      tx_dir_r <= 1'b0;
      reg_req_r <= 1'b0;
      reg_we_r <= 1'b0;
      reg_wide_r <= 1'b0;
      reg_addr_r <= 16'h0000;
      reg_wdata_r <= 32'h00000000;
      drop_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      exc_r <= exc_nxt;
      pend_r <= pend_nxt;
      rd_buf_r <= rd_buf_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_byte_r <= tx_byte_nxt;
      tx_dir_r <= tx_dir_nxt;
      reg_req_r <= reg_req_nxt;
      reg_we_r <= reg_we_nxt;
      reg_wide_r <= reg_wide_nxt;
      reg_addr_r <= reg_addr_nxt;
      reg_wdata_r <= reg_wdata_nxt;
      drop_r <= drop_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign tx_valid = tx_valid_r;
  assign tx_byte = tx_byte_r;
  assign tx_drive_en = tx_dir_r;
  assign reg_req = reg_req_r;
  assign reg_we = reg_we_r;
  assign reg_wide = reg_wide_r;
  assign reg_addr = reg_addr_r;
  assign reg_wdata = reg_wdata_r;
  assign frame_drop = drop_r;

endmodule

// File: sim/rsp_engine_chk.sv
`timescale 1ns/1ps
module rsp_engine_chk import rsp_pkg::*; #(
  parameter int CLK_HZ = CLK_FREQ_HZ
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // settings
  input wire logic [2:0] bit_rate_setting,
  input wire logic [1:0] character_format_setting,
  // link
  input wire logic rx_valid,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_ready,
  input wire logic tx_idle,
  input wire logic tx_drive_en,
  // store and status
  input wire logic reg_req,
  input wire logic frame_drop
);
  // ****************************************
  // silence count and request memory
  // ****************************************
  logic [31:0] idle_r, idle_nxt, gap;
  logic seen_r, seen_nxt;
  longint baud, bits;
  always_comb begin
    baud = (bit_rate_setting > BAUD_MAX_SEL) ? BAUD_TAB[2]
                                              : BAUD_TAB[bit_rate_setting];
    bits = (character_format_setting == FMT_1S_NONE) ? 10 : 11;
    gap = 32'((longint'(CLK_HZ) * bits * 7 + 2 * baud - 1) / (2 * baud));
    idle_nxt = rx_valid ? 32'h0 : idle_r + 32'(idle_r != '1);
    seen_nxt = rx_valid | (seen_r & !tx_drive_en);
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      idle_r <= 32'h0;
      seen_r <= 1'b0;
    end else begin
      idle_r <= idle_nxt;
      seen_r <= seen_nxt;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  tx_hold_a:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
      else $error("tx byte changed before taken");
  tx_space_a:
    assert property (tx_valid && tx_ready |=> !tx_valid)
      else $error("tx valid held after byte taken");
  drive_cover_a:
    assert property (tx_valid |-> tx_drive_en)
      else $error("byte offered with driver off");
  drive_release_a:
    assert property ($fell(tx_drive_en) |-> $past(tx_idle) && !$past(tx_valid))
      else $error("driver released before line idle");
  reply_gap_a:
    assert property ($rose(tx_drive_en) |-> idle_r >= gap - 32'h2)
      else $error("reply started before frame silence");
  store_gap_a:
    assert property (reg_req |-> idle_r >= gap - 32'h2)
      else $error("store access before frame silence");
  slave_only_a:
    assert property ($rose(tx_drive_en) |-> seen_r)
      else $error("reply without a request");
  drop_quiet_a:
    assert property (frame_drop |=> (!tx_drive_en && !reg_req) [*8])
      else $error("activity after dropped frame");
endmodule

bind rsp_engine rsp_engine_chk #(.CLK_HZ(CLK_HZ)) chk (
  .clk_sys, .nrst, .bit_rate_setting, .character_format_setting, .rx_valid,
  .tx_valid, .tx_byte, .tx_ready, .tx_idle, .tx_drive_en, .reg_req,
  .frame_drop
);

// File: sim/rsp_host_model.sv
`timescale 1ns/1ps
module rsp_host_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // pacing
  input wire logic slow,
  // link
  output logic rx_valid = 1'b0,
  output logic [7:0] rx_byte = 8'h00,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready,
  output logic tx_idle
);
  // ****************************************
  // uart stand-in and frame sender
  // ****************************************
  logic [7:0] got [$];
  logic [3:0] busy = 4'h0;
  assign tx_ready = (busy == 4'h0);
  assign tx_idle = (busy == 4'h0);
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      busy <= 4'h0;
    else if (tx_valid && tx_ready) begin
      busy <= slow ? 4'hc : 4'h2;
      got.push_back(tx_byte);
    end else if (busy != 4'h0)
      busy <= busy - 4'h1;
  end
  function automatic logic [15:0] crc16(input logic [7:0] q [$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  task automatic send(input logic [7:0] body [$], input bit bad);
    logic [15:0] c;
    c = crc16(body) ^ {15'h0000, bad};
    body.push_back(c[7:0]);
    body.push_back(c[15:8]);
    repeat (300) @(posedge clk_sys);
    foreach (body[i]) begin
      rx_valid <= 1'b1;
      rx_byte <= body[i];
      @(posedge clk_sys);
      rx_valid <= 1'b0;
      rx_byte <= ~body[i];
      repeat (slow ? 20 : 1) @(posedge clk_sys);
    end
  endtask
endmodule

// File: sim/rsp_engine_bench.sv
`timescale 1ns/1ps
module rsp_engine_bench import rsp_pkg::*;;
  typedef logic [7:0] rsp_bq_t [$];
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] rate = 3'h5;
  logic [1:0] fmt = 2'h0;
  logic order = 1'b0;
  logic slow = 1'b0;
  logic err_next = 1'b0;
  logic reg_ack = 1'b0;
  logic reg_err = 1'b0;
  logic [15:0] reg_rdata = 16'h0000;
  logic rx_valid, tx_valid, tx_ready, tx_idle, tx_drive_en;
  logic [7:0] rx_byte, tx_byte;
  logic reg_req, reg_we, reg_wide, frame_drop;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int drops = 0;
  always #10 clk_sys = ~clk_sys;
  rsp_engine #(.CLK_HZ(200000)) uut (
    .clk_sys, .nrst, .station_address_setting(8'h01),
    .bit_rate_setting(rate), .character_format_setting(fmt),
    .word_order_setting(order), .rx_valid, .rx_byte, .tx_valid, .tx_byte,
    .tx_ready, .tx_idle, .tx_drive_en, .reg_req, .reg_we, .reg_wide,
    .reg_addr, .reg_wdata, .reg_ack, .reg_err, .reg_rdata, .frame_drop
  );
  rsp_host_model host (
    .clk_sys, .nrst, .slow, .rx_valid, .rx_byte, .tx_valid, .tx_byte,
    .tx_ready, .tx_idle
  );
  // ****************************************
  // store stand-in and timeout
  // ****************************************
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    drops <= drops + int'(frame_drop);
    reg_ack <= reg_req;
    reg_err <= reg_req & err_next;
    reg_rdata <= reg_req ? reg_addr ^ 16'h0f0f : ~reg_rdata;
    if (cycles == 40000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic end_sim();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  function automatic rsp_bq_t q_of(input logic [87:0] v, input int n);
    rsp_bq_t q;
    for (int i = n - 1; i >= 0; i--)
      q.push_back(v[i*8 +: 8]);
    return q;
  endfunction
  task automatic run(input rsp_bq_t req, input rsp_bq_t exp, input bit bad);
    logic [15:0] c;
    c = host.crc16(exp);
    host.got.delete();
    host.send(req, bad);
    if (exp.size() > 0) begin
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
    end
    for (int i = 0; i < 2000 && (i < 200 || tx_drive_en ||
         host.got.size() < exp.size()); i++)
      @(posedge clk_sys);
    check(host.got.size(), exp.size());
    foreach (exp[i])
      check(32'(host.got[i]), 32'(exp[i]));
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_read();
    run(q_of(48'h01031e240002, 6), q_of(56'h010304112b112a, 7), 1'b0);
    check({reg_we, reg_addr}, {1'b0, 16'h1e25});
  endtask
  task automatic t_wr16();
    rate <= 3'h4;
    fmt <= 2'h3;
    slow <= 1'b1;
    run(q_of(48'h0106010a0bb8, 6), q_of(48'h0106010a0bb8, 6), 1'b0);
    check({reg_we, reg_wide, reg_addr}, {2'b10, 16'h010a});
    check(reg_wdata, 32'h00000bb8);
    rate <= 3'h5;
    fmt <= 2'h0;
    slow <= 1'b0;
  endtask
  task automatic t_wr32();
    for (int o = 0; o < 2; o++) begin
      order <= o[0];
      run(q_of(88'h0110070900020400 << 24 | 88'h0007d0, 11),
          q_of(48'h011007090002, 6), 1'b0);
      check(reg_wdata, o ? 32'h07d00000 : 32'h000007d0);
      check({reg_we, reg_wide}, 2'b11);
    end
  endtask
  task automatic t_exc();
    fmt <= 2'h1;
    run(q_of(48'h010500010001, 6), q_of(24'h018501, 3), 1'b0);
    fmt <= 2'h2;
    run(q_of(48'h01061e010005, 6), q_of(24'h018602, 3), 1'b0);
    run(q_of(48'h010300010009, 6), q_of(24'h018303, 3), 1'b0);
    err_next <= 1'b1;
    run(q_of(48'h010600010005, 6), q_of(24'h018604, 3), 1'b0);
    err_next <= 1'b0;
    fmt <= 2'h0;
  endtask
  task automatic t_drop();
    int d;
    rsp_bq_t none;
    d = drops;
    run(q_of(48'h0106010a0bb8, 6), none, 1'b1);
    check(32'(drops - d), 32'h1);
    run(q_of(48'h020300010001, 6), none, 1'b0);
    check(32'(drops - d), 32'h1);
  endtask
  initial begin
    @(posedge clk_sys);
    #1 check({tx_valid, tx_drive_en, reg_req, frame_drop}, 32'h0);
    @(posedge clk_sys);
    nrst <= 1'b1;
    check(host.crc16(q_of(48'h0106010a0bb8, 6)), 32'h76af);
    t_read();
    t_wr16();
    t_wr32();
    t_exc();
    t_drop();
    end_sim();
  end
endmodule
